// file: design/lxr_relay.sv
// Two-stage excitation loss relay with APB settings and interrupt.
//
// Function
// - Each stage has operation off/on, default off.
// - Start-only setting suppresses the stage trip.
// - Impedance evaluated only above minimum phase current.
// - Near reactance point per stage, 5..500 percent.
// - Far reactance point per stage, 5..1000 percent.
// - Per-stage delay 50..60000 ms, default 100.
// - Start and trip flags for each stage.
// - General block input suppresses all stage flags.
// - Voltage supervision block suppresses all stage flags.
// - Loop impedance is voltage difference over current difference.
// - Stage operates when impedance lies inside circle.
// - Circle centred on negative reactance, near-to-far diameter.
// - Two independently parameterised circles, one per stage.
// - Stage decision is OR of three loops.
`timescale 1ns/1ps
`default_nettype none

module lxr_relay #(
    parameter int CYCLES_PER_MS = lxr_pkg::CYCLES_PER_MS,
    parameter int I_RATED = 16384
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lxr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Phasor samples from the front end, phases 1..3 in elements 0..2.
    input wire logic sample_valid,
    input wire logic [2:0][lxr_pkg::SMP_W-1:0] v_re,
    input wire logic [2:0][lxr_pkg::SMP_W-1:0] v_im,
    input wire logic [2:0][lxr_pkg::SMP_W-1:0] i_re,
    input wire logic [2:0][lxr_pkg::SMP_W-1:0] i_im,
    // Blocking inputs from the surrounding logic.
    input wire logic function_block_in,
    input wire logic vt_supervision_block_in,
    // Stage flags.
    output logic stage1_start_flag,
    output logic stage1_trip_flag,
    output logic stage2_start_flag,
    output logic stage2_trip_flag,
    // Interrupt.
    output logic irq
);

    localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);
    localparam int SW = lxr_pkg::SET_W;
    localparam int DW = lxr_pkg::DLY_W;
    localparam int NS = lxr_pkg::NSTAGE;
    localparam int NE = lxr_pkg::NEV;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_MS - 1);
    localparam logic [47:0] I_RATED_W = 48'(I_RATED);

    // Refuse settings that the divider or the current gate cannot serve.
    if (CYCLES_PER_MS < 1) begin : g_chk_div
        $error("CYCLES_PER_MS must be at least one.");
    end
    if (I_RATED < 1 || I_RATED > 32767) begin : g_chk_rated
        $error("I_RATED must lie in 1 to 32767.");
    end

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [NS-1:0] op;
        logic [NS-1:0] so;
        logic [lxr_pkg::IMIN_W-1:0] imin;
        logic [NS-1:0][SW-1:0] near;
        logic [NS-1:0][SW-1:0] far;
        logic [NS-1:0][DW-1:0] dly;
        logic [NS-1:0] hit;
        logic [NS-1:0] start;
        logic [NS-1:0] trip_q;
        logic [NE-1:0] ev;
        logic [NE-1:0] mask;
        logic [31:0] prdata;
    } lxr_state_t;

    lxr_state_t s_r;
    lxr_state_t s_nxt;
    logic [NS-1:0] trip;
    logic ms_tick;

    // Holds a written setting inside its permitted range.
    function automatic logic [SW-1:0] clamp_set(
        input logic [SW-1:0] val,
        input logic [SW-1:0] lo,
        input logic [SW-1:0] hi
    );
        clamp_set = (val < lo) ? lo : ((val > hi) ? hi : val);
    endfunction : clamp_set

    // True when the phase current magnitude exceeds imin percent.
    function automatic logic current_ok(
        input logic [lxr_pkg::SMP_W-1:0] re,
        input logic [lxr_pkg::SMP_W-1:0] im,
        input logic [lxr_pkg::IMIN_W-1:0] imin
    );
        logic signed [47:0] r;
        logic signed [47:0] m;
        logic [47:0] mag2;
        logic [47:0] lim;
        r = 48'($signed(re));
        m = 48'($signed(im));
        mag2 = 48'(r * r + m * m) * lxr_pkg::PCT_SQ;
        lim = 48'(imin) * I_RATED_W;
        current_ok = mag2 > lim * lim;
    endfunction : current_ok

    // Circle test without division: with Z = U / I, Z lies inside the
    // circle when |2K*U + j(near+far)*I| < (far-near)*|I|, K the scale.
    function automatic logic in_circle(
        input logic signed [39:0] ur,
        input logic signed [39:0] ui,
        input logic signed [39:0] ir,
        input logic signed [39:0] ii,
        input logic [SW-1:0] near,
        input logic [SW-1:0] far
    );
        logic signed [39:0] sum;
        logic signed [39:0] dia;
        logic signed [39:0] a;
        logic signed [39:0] b;
        logic signed [79:0] lhs;
        logic signed [79:0] rhs;
        sum = 40'(near) + 40'(far);
        dia = 40'(far) - 40'(near);
        a = lxr_pkg::ZSCALE2 * ur - sum * ii;
        b = lxr_pkg::ZSCALE2 * ui + sum * ir;
        lhs = 80'(a) * 80'(a) + 80'(b) * 80'(b);
        rhs = 80'(dia) * 80'(dia) * (80'(ir) * 80'(ir) + 80'(ii) * 80'(ii));
        // An inverted pair of points describes no circle at all.
        in_circle = (far > near) && (lhs < rhs);
    endfunction : in_circle

    // One-millisecond time base for the stage timers.
    assign ms_tick = (s_r.div == DIV_LAST);

    // Next-state logic: divider, loop evaluation, flags and registers.
    always_comb begin
        logic [2:0] ph_ok;
        logic [NS-1:0] loop_or;
        logic signed [39:0] ur;
        logic signed [39:0] ui;
        logic signed [39:0] ir;
        logic signed [39:0] ii;
        logic [NE-1:0] ev_now;
        logic [NE-1:0] clr;
        logic wr;
        logic setup_rd;
        logic [31:0] rd;
        int kb;
        ph_ok = '0;
        loop_or = '0;
        ur = '0;
        ui = '0;
        ir = '0;
        ii = '0;
        ev_now = '0;
        clr = '0;
        rd = '0;
        kb = 0;
        wr = psel && penable && pwrite;
        setup_rd = psel && !penable && !pwrite;
        s_nxt = s_r;
        s_nxt.div = ms_tick ? '0 : DIV_W'(s_r.div + 1'b1);

        // Each new sample set re-decides both stages.
        for (int p = 0; p < lxr_pkg::NPHASE; p++) begin
            ph_ok[p] = current_ok(i_re[p], i_im[p], s_r.imin);
        end
        for (int k = 0; k < lxr_pkg::NPHASE; k++) begin
            kb = (k == lxr_pkg::NPHASE - 1) ? 0 : k + 1;
            ur = 40'($signed(v_re[k])) - 40'($signed(v_re[kb]));
            ui = 40'($signed(v_im[k])) - 40'($signed(v_im[kb]));
            ir = 40'($signed(i_re[k])) - 40'($signed(i_re[kb]));
            ii = 40'($signed(i_im[k])) - 40'($signed(i_im[kb]));
            for (int st = 0; st < NS; st++) begin
                // Each stage uses only its own pair of points.
                if (ph_ok[k] && ph_ok[kb] &&
                    in_circle(ur, ui, ir, ii, s_r.near[st], s_r.far[st])) begin
                    loop_or[st] = 1'b1;
                end
            end
        end
        if (sample_valid) begin
            s_nxt.hit = loop_or;
        end

        // Start follows the held decision; blocks act at once.
        for (int st = 0; st < NS; st++) begin
            s_nxt.start[st] = s_r.op[st] && s_r.hit[st] &&
                              !function_block_in &&
                              !vt_supervision_block_in;
        end
        s_nxt.trip_q = trip;

        // Rising edges of the four flags are the interrupt events.
        ev_now[lxr_pkg::EV_ST1] = s_nxt.start[0] && !s_r.start[0];
        ev_now[lxr_pkg::EV_TR1] = trip[0] && !s_r.trip_q[0];
        ev_now[lxr_pkg::EV_ST2] = s_nxt.start[1] && !s_r.start[1];
        ev_now[lxr_pkg::EV_TR2] = trip[1] && !s_r.trip_q[1];

        // Writes take effect in the access phase; settings are clamped.
        if (wr) begin
            case (paddr)
                lxr_pkg::OFS_CTRL: begin
                    s_nxt.op = pwdata[lxr_pkg::CTRL_OP +: NS];
                    s_nxt.so = pwdata[lxr_pkg::CTRL_SO +: NS];
                end
                lxr_pkg::OFS_IMIN: begin
                    s_nxt.imin = lxr_pkg::IMIN_W'(clamp_set(
                        SW'(pwdata[7:0]), SW'(lxr_pkg::IMIN_MIN),
                        SW'(lxr_pkg::IMIN_MAX)));
                end
                lxr_pkg::OFS_NEAR1: begin
                    s_nxt.near[0] = clamp_set(pwdata[SW-1:0],
                        lxr_pkg::NEAR_MIN, lxr_pkg::NEAR_MAX);
                end
                lxr_pkg::OFS_FAR1: begin
                    s_nxt.far[0] = clamp_set(pwdata[SW-1:0],
                        lxr_pkg::FAR_MIN, lxr_pkg::FAR_MAX);
                end
                lxr_pkg::OFS_NEAR2: begin
                    s_nxt.near[1] = clamp_set(pwdata[SW-1:0],
                        lxr_pkg::NEAR_MIN, lxr_pkg::NEAR_MAX);
                end
                lxr_pkg::OFS_FAR2: begin
                    s_nxt.far[1] = clamp_set(pwdata[SW-1:0],
                        lxr_pkg::FAR_MIN, lxr_pkg::FAR_MAX);
                end
                lxr_pkg::OFS_DLY1: begin
                    s_nxt.dly[0] = DW'(clamp_set(SW'(pwdata[DW-1:0]),
                        SW'(lxr_pkg::DLY_MIN),
                        SW'(lxr_pkg::DLY_MAX)));
                end
                lxr_pkg::OFS_DLY2: begin
                    s_nxt.dly[1] = DW'(clamp_set(SW'(pwdata[DW-1:0]),
                        SW'(lxr_pkg::DLY_MIN),
                        SW'(lxr_pkg::DLY_MAX)));
                end
                lxr_pkg::OFS_IRQ_STAT: begin
                    clr = pwdata[NE-1:0];
                end
                lxr_pkg::OFS_IRQ_MASK: begin
                    s_nxt.mask = pwdata[NE-1:0];
                end
                default: begin
                    clr = '0;
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        s_nxt.ev = (s_r.ev & ~clr) | ev_now;

        // Read data is captured in the setup cycle and held for access.
        case (paddr)
            lxr_pkg::OFS_CTRL: begin
                rd[lxr_pkg::CTRL_OP +: NS] = s_r.op;
                rd[lxr_pkg::CTRL_SO +: NS] = s_r.so;
            end
            lxr_pkg::OFS_IMIN: rd = 32'(s_r.imin);
            lxr_pkg::OFS_NEAR1: rd = 32'(s_r.near[0]);
            lxr_pkg::OFS_FAR1: rd = 32'(s_r.far[0]);
            lxr_pkg::OFS_NEAR2: rd = 32'(s_r.near[1]);
            lxr_pkg::OFS_FAR2: rd = 32'(s_r.far[1]);
            lxr_pkg::OFS_DLY1: rd = 32'(s_r.dly[0]);
            lxr_pkg::OFS_DLY2: rd = 32'(s_r.dly[1]);
            lxr_pkg::OFS_FLAGS: begin
                rd[lxr_pkg::EV_ST1] = s_r.start[0];
                rd[lxr_pkg::EV_TR1] = trip[0];
                rd[lxr_pkg::EV_ST2] = s_r.start[1];
                rd[lxr_pkg::EV_TR2] = trip[1];
                rd[lxr_pkg::FL_BLK] = function_block_in;
                rd[lxr_pkg::FL_VTS] = vt_supervision_block_in;
            end
            lxr_pkg::OFS_IRQ_STAT: rd = 32'(s_r.ev);
            lxr_pkg::OFS_IRQ_MASK: rd = 32'(s_r.mask);
            default: rd = '0;
        endcase
        if (setup_rd) begin
            s_nxt.prdata = rd;
        end
    end

    // State register with documented defaults.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
            s_r.imin <= lxr_pkg::IMIN_RST;
            for (int st = 0; st < NS; st++) begin
                s_r.near[st] <= lxr_pkg::NEAR_RST;
                s_r.far[st] <= lxr_pkg::FAR_RST;
                s_r.dly[st] <= lxr_pkg::DLY_RST;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // One timer per stage; blocking drops start and so clears trip too.
    for (genvar g = 0; g < NS; g++) begin : g_stage
        lxr_stage_timer #(
            .DLY_W(DW)
        ) u_tmr (
            .clk(clk),
            .srst(srst),
            .ms_tick(ms_tick),
            .start(s_r.start[g]),
            .start_only(s_r.so[g]),
            .delay_ms(s_r.dly[g]),
            .trip(trip[g])
        );
    end

    // Zero-wait slave; only the mapped words answer without error.
    assign pready = 1'b1;
    always_comb begin
        case (paddr)
            lxr_pkg::OFS_CTRL, lxr_pkg::OFS_IMIN, lxr_pkg::OFS_NEAR1,
            lxr_pkg::OFS_FAR1, lxr_pkg::OFS_NEAR2, lxr_pkg::OFS_FAR2,
            lxr_pkg::OFS_DLY1, lxr_pkg::OFS_DLY2, lxr_pkg::OFS_FLAGS,
            lxr_pkg::OFS_IRQ_STAT, lxr_pkg::OFS_IRQ_MASK: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end
    assign prdata = s_r.prdata;

    // Flag outputs.
    assign stage1_start_flag = s_r.start[0];
    assign stage1_trip_flag = trip[0];
    assign stage2_start_flag = s_r.start[1];
    assign stage2_trip_flag = trip[1];
    assign irq = |(s_r.ev & s_r.mask);

endmodule : lxr_relay

`default_nettype wire

// file: design/lxr_pkg.sv
// Shared constants for the two-stage excitation loss relay.
package lxr_pkg;

    // Clock and millisecond time base.
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

    // Datapath and setting widths.
    localparam int SMP_W = 16;
    localparam int SET_W = 17;
    localparam int DLY_W = 16;
    localparam int IMIN_W = 5;
    localparam int ADDR_W = 8;
    localparam int NSTAGE = 2;
    localparam int NPHASE = 3;
    localparam int NEV = 4;

    // Reactance settings are held in hundredths of a percent.
    localparam logic [SET_W-1:0] NEAR_MIN = 17'h001f4;
    localparam logic [SET_W-1:0] NEAR_MAX = 17'h0c350;
    localparam logic [SET_W-1:0] NEAR_RST = 17'h003e8;
    localparam logic [SET_W-1:0] FAR_MIN = 17'h001f4;
    localparam logic [SET_W-1:0] FAR_MAX = 17'h186a0;
    localparam logic [SET_W-1:0] FAR_RST = 17'h02710;

    // Delay in milliseconds, minimum current in percent.
    localparam logic [DLY_W-1:0] DLY_MIN = 16'h0032;
    localparam logic [DLY_W-1:0] DLY_MAX = 16'hea60;
    localparam logic [DLY_W-1:0] DLY_RST = 16'h0064;
    localparam logic [IMIN_W-1:0] IMIN_MIN = 5'h0a;
    localparam logic [IMIN_W-1:0] IMIN_MAX = 5'h1e;
    localparam logic [IMIN_W-1:0] IMIN_RST = 5'h14;

    // Twice the hundredths-of-percent scale, and percent squared.
    localparam logic signed [39:0] ZSCALE2 = 40'sh0000004e20;
    localparam logic [47:0] PCT_SQ = 48'h000000002710;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IMIN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_NEAR1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FAR1 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_NEAR2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FAR2 = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DLY1 = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_DLY2 = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h28;

    // Control field positions: operation at 0..1, start-only at 2..3.
    localparam int CTRL_OP = 0;
    localparam int CTRL_SO = 2;

    // Event bits: start and trip of stage 1, then of stage 2.
    localparam int EV_ST1 = 0;
    localparam int EV_TR1 = 1;
    localparam int EV_ST2 = 2;
    localparam int EV_TR2 = 3;
    localparam int FL_BLK = 4;
    localparam int FL_VTS = 5;

endpackage : lxr_pkg

// file: design/lxr_stage_timer.sv
// Definite-time delay from stage start to stage trip.
`timescale 1ns/1ps
`default_nettype none

module lxr_stage_timer #(
    parameter int DLY_W = lxr_pkg::DLY_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Millisecond time base.
    input wire logic ms_tick,
    // Stage condition and settings.
    input wire logic start,
    input wire logic start_only,
    input wire logic [DLY_W-1:0] delay_ms,
    // Delayed trip.
    output logic trip
);

    typedef struct packed {
        logic [DLY_W-1:0] count;
        logic trip;
    } lxr_tmr_t;

    lxr_tmr_t s_r;
    lxr_tmr_t s_nxt;

    // The count restarts whenever start drops, so a swinging impedance
    // that leaves the circle never accumulates time across visits.
    always_comb begin
        s_nxt = s_r;
        if (!start) begin
            s_nxt.count = '0;
        end else if (ms_tick && s_r.count < delay_ms) begin
            s_nxt.count = s_r.count + 1'b1;
        end
        s_nxt.trip = start && !start_only &&
                     s_nxt.count >= delay_ms;
    end

    // State register.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trip = s_r.trip;

endmodule : lxr_stage_timer

`default_nettype wire

// file: dv/lxr_relay_asserts.sv
// Port checker for the excitation loss relay.
`timescale 1ns/1ps
`default_nettype none

module lxr_relay_asserts #(
    parameter int CYCLES_PER_MS = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Bus and blocking inputs.
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic function_block_in,
    input wire logic vt_supervision_block_in,
    // Stage flags.
    input wire logic stage1_start_flag,
    input wire logic stage1_trip_flag,
    input wire logic stage2_start_flag,
    input wire logic stage2_trip_flag
);
    // Shortest delay, less one partial millisecond and some slack.
    localparam int MIN_CYC = 48 * CYCLES_PER_MS;
    int cnt1_r;
    int cnt2_r;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Cycles that each start flag has stood high without a break.
    always_ff @(posedge clk) begin
        cnt1_r <= (srst || !stage1_start_flag) ? 0 : cnt1_r + 1;
        cnt2_r <= (srst || !stage2_start_flag) ? 0 : cnt2_r + 1;
    end

    // A block held for two edges must have cleared the timers as well.
    sequence blk_held;
        function_block_in ##1 function_block_in;
    endsequence
    sequence vts_held;
        vt_supervision_block_in ##1 vt_supervision_block_in;
    endsequence

    blk_start_a: assert property (
        function_block_in |=> !stage1_start_flag && !stage2_start_flag)
        else $error("start flag while blocked");
    vts_start_a: assert property (
        vt_supervision_block_in |=> !stage1_start_flag && !stage2_start_flag)
        else $error("start flag while supervision blocks");
    blk_trip_a: assert property (
        blk_held |=> !stage1_trip_flag && !stage2_trip_flag)
        else $error("trip flag while blocked");
    vts_trip_a: assert property (
        vts_held |=> !stage1_trip_flag && !stage2_trip_flag)
        else $error("trip flag while supervision blocks");
    trip1_delay_a: assert property (
        $rose(stage1_trip_flag) |-> cnt1_r >= MIN_CYC)
        else $error("stage 1 trip too early");
    trip2_delay_a: assert property (
        $rose(stage2_trip_flag) |-> cnt2_r >= MIN_CYC)
        else $error("stage 2 trip too early");
    trip1_clear_a: assert property (
        $fell(stage1_start_flag) |=> !stage1_trip_flag)
        else $error("stage 1 trip outlived start");
    trip2_clear_a: assert property (
        $fell(stage2_start_flag) |=> !stage2_trip_flag)
        else $error("stage 2 trip outlived start");
    slverr_phase_a: assert property (
        pslverr |-> psel && penable)
        else $error("error response outside access phase");
endmodule : lxr_relay_asserts

`default_nettype wire

// file: dv/lxr_frontend_model.sv
// Sampling front end model: phasors of a pure reactance seen by the relay.
`timescale 1ns/1ps
`default_nettype none

module lxr_frontend_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Current amplitude in counts and reactance in percent.
    input wire logic [15:0] amp,
    input wire logic [15:0] xpct,
    // Samples toward the relay.
    output logic sample_valid,
    output logic [2:0][15:0] v_re,
    output logic [2:0][15:0] v_im,
    output logic [2:0][15:0] i_re,
    output logic [2:0][15:0] i_im
);
    logic [2:0] cnt_r;
    logic [15:0] vh;
    logic [2:0][15:0] vi_d;
    logic [2:0][15:0] ii_d;

    // Phase 3 carries no current, so only loop 1-2 passes the gate.
    assign vh = 16'((32'(amp) * 32'(xpct)) / 32'd100);
    assign vi_d = {16'h0000, vh, -vh};
    assign ii_d = {16'h0000, -amp, amp};
    assign sample_valid = (cnt_r == 3'h7);

    // One sample every eight cycles.
    always_ff @(posedge clk) begin
        cnt_r <= srst ? 3'h0 : cnt_r + 3'h1;
    end

    // Between samples the lines show the inverse, so stale data is useless.
    assign v_im = sample_valid ? vi_d : ~vi_d;
    assign i_re = sample_valid ? ii_d : ~ii_d;
    assign v_re = sample_valid ? '0 : '1;
    assign i_im = sample_valid ? '0 : '1;
endmodule : lxr_frontend_model

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the excitation loss relay.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sv, irq, st1, tr1, st2, tr2;
    logic blk = 1'b0, vts = 1'b0;
    logic [15:0] amp = 16'h2000, xpct = 16'h0000;
    logic [2:0][15:0] vr, vi, ir, ii;
    logic [3:0] fl;
    int mismatches = 0;
    int num_checks = 0;

    assign fl = {tr2, st2, tr1, st1};

    // Divider of four cycles per millisecond: a 25 ns period.
    always #12.5 clk = ~clk;

    lxr_relay #(.CYCLES_PER_MS(4)) i_lxr_relay (.clk(clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sv), .v_re(vr), .v_im(vi),
        .i_re(ir), .i_im(ii), .function_block_in(blk),
        .vt_supervision_block_in(vts), .stage1_start_flag(st1),
        .stage1_trip_flag(tr1), .stage2_start_flag(st2),
        .stage2_trip_flag(tr2), .irq(irq));
    lxr_frontend_model i_lxr_frontend_model (.clk(clk), .srst(srst),
        .amp(amp), .xpct(xpct), .sample_valid(sv), .v_re(vr), .v_im(vi),
        .i_re(ir), .i_im(ii));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One bus transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_fl(input logic [3:0] m, input logic [3:0] v);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((fl & m) !== v && n < 400);
        chk(32'(fl & m), 32'(v));
    endtask : wait_fl

    task automatic set_z(input logic [15:0] a, input logic [15:0] x);
        @(posedge clk);
        amp <= a;
        xpct <= x;
    endtask : set_z

    task automatic t_regs();
        logic [31:0] e [8];
        e = '{32'h0, 32'h14, 32'h3e8, 32'h2710, 32'h3e8, 32'h2710,
              32'h64, 32'h64};
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(rd, e[k]);
        end
    endtask : t_regs

    // Out-of-range settings land on the limits; the last three restore.
    task automatic t_clamp();
        logic [7:0] a [11];
        logic [31:0] w [11];
        logic [31:0] e [11];
        a = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h18, 8'h18,
              8'h04, 8'h08, 8'h0c};
        w = '{32'h5, 32'h1f, 32'h1, 32'hffff, 32'h1, 32'h1ffff, 32'ha,
              32'hffff, 32'h14, 32'h3e8, 32'h2710};
        e = '{32'ha, 32'h1e, 32'h1f4, 32'hc350, 32'h1f4, 32'h186a0,
              32'h32, 32'hea60, 32'h14, 32'h3e8, 32'h2710};
        for (int k = 0; k < 11; k++) begin
            apb(1'b1, a[k], w[k]);
            apb(1'b0, a[k], 32'h0);
            chk(rd, e[k]);
        end
        apb(1'b1, 8'h40, 32'h1);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
    endtask : t_clamp

    task automatic t_off();
        set_z(16'h2000, 16'h0032);
        repeat (40) @(negedge clk);
        chk(32'(fl), 32'h0);
    endtask : t_off

    task automatic t_start_trip();
        int n;
        apb(1'b1, 8'h18, 32'h32);
        apb(1'b1, 8'h00, 32'h1);
        wait_fl(4'hf, 4'h1);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tr1 !== 1'b1 && n < 400);
        chk(32'(n >= 194 && n <= 206), 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h3);
    endtask : t_start_trip

    // Blocks clear start at the next edge and trip one edge later.
    task automatic t_block();
        @(posedge clk);
        blk <= 1'b1;
        repeat (3) @(negedge clk);
        chk(32'(fl), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h10);
        @(posedge clk);
        blk <= 1'b0;
        wait_fl(4'hf, 4'h1);
        @(posedge clk);
        vts <= 1'b1;
        repeat (3) @(negedge clk);
        chk(32'(fl), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h20);
        @(posedge clk);
        vts <= 1'b0;
        wait_fl(4'hf, 4'h1);
    endtask : t_block

    task automatic t_irq();
        set_z(16'h2000, 16'h0000);
        wait_fl(4'hf, 4'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk(rd, 32'h3);
        chk(32'(irq), 32'h0);
        apb(1'b1, 8'h28, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, 8'h24, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk(rd, 32'h1);
    endtask : t_irq

    task automatic t_start_only();
        apb(1'b1, 8'h00, 32'h5);
        set_z(16'h2000, 16'h0032);
        wait_fl(4'hf, 4'h1);
        repeat (260) @(negedge clk);
        chk(32'(fl), 32'h1);
    endtask : t_start_only

    // 2000 counts lie between the 10 and 20 percent current limits.
    task automatic t_min();
        apb(1'b1, 8'h00, 32'h1);
        set_z(16'h07d0, 16'h0032);
        wait_fl(4'h5, 4'h0);
        repeat (40) @(negedge clk);
        chk(32'(fl), 32'h0);
        apb(1'b1, 8'h04, 32'ha);
        wait_fl(4'h5, 4'h1);
        apb(1'b1, 8'h04, 32'h14);
        wait_fl(4'h5, 4'h0);
    endtask : t_min

    task automatic t_stage2();
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h10, 32'h3a98);
        apb(1'b1, 8'h14, 32'h7530);
        apb(1'b1, 8'h1c, 32'h32);
        set_z(16'h2000, 16'h00c8);
        wait_fl(4'h5, 4'h4);
        wait_fl(4'hc, 4'hc);
        set_z(16'h2000, 16'h0032);
        wait_fl(4'h5, 4'h1);
        set_z(16'h2000, 16'h0078);
        wait_fl(4'h5, 4'h0);
    endtask : t_stage2

    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // Main sequence after eight cycles of reset.
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_clamp();
        t_off();
        t_start_trip();
        t_block();
        t_irq();
        t_start_only();
        t_min();
        t_stage2();
        print_verdict();
    end

    // The tests need about a thousand cycles; this limit is far beyond.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : tb

bind lxr_relay lxr_relay_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS))
    i_lxr_relay_asserts (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pslverr(pslverr),
    .function_block_in(function_block_in),
    .vt_supervision_block_in(vt_supervision_block_in),
    .stage1_start_flag(stage1_start_flag),
    .stage1_trip_flag(stage1_trip_flag),
    .stage2_start_flag(stage2_start_flag),
    .stage2_trip_flag(stage2_trip_flag));

`default_nettype wire
